//--- vbr_engine.v
`timescale 1ns/1ns
`include "vbr_defs.vh"

// Contract
// - One queue unless multiqueue negotiated; then queue count field applies.
// - Bits 1, 2, 4 flag segment size, segment count and geometry valid.
// - Bits 6 and 10 flag block size and topology fields valid.
// - Read-only device fails every write request.
// - Bit 9 advertises flush; bit 11 advertises switchable cache mode.
// - Bits 13 and 14 advertise discard and write-zeroes with limits.
// - Capacity in 512-byte sectors always readable.
// - Discard and write-zeroes limits counted in 512-byte units.
// - Config little-endian, except legacy uses guest native order.
// - Cache mode reads 0 writethrough, 1 writeback, reflecting actual mode.
// - Flush always offered, and whenever cache mode switch offered.
// - Switchable cache without flush initialises mode to writethrough.
// - Padding bytes read as zero.
// - Legacy: status writes keep mode, except ready without cache feature.
// - Legacy: driver feature changes never alter cache mode.
// - Request: type, reserved, sector, data, status; read 0 write 1 flush 4.
// - Sector is byte offset over 512; data moves in 512-byte blocks.
// - Discard 11 and write-zeroes 13 carry one to limit segments.
// - Segment: 64-bit sector, 32-bit count, flags with unmap bit 0.
// - Unmap honoured only in write-zeroes; deallocated range reads zero.
// - Status 0 success, 1 I/O error, 2 unsupported.
module vbr_engine #(
	parameter [63:0] CAPACITY       = 64'h0000000000100000,
	parameter [31:0] SIZE_LIMIT     = 32'h00010000,
	parameter [31:0] SEG_LIMIT      = 32'h00000080,
	parameter [31:0] GEOMETRY       = 32'h203F0400,
	parameter [31:0] BLK_BYTES      = 32'h00000200,
	parameter [31:0] TOPO0          = 32'h00010000,
	parameter [31:0] OPT_IO         = 32'h00000008,
	parameter [15:0] QUEUES         = 16'h0004,
	parameter [31:0] DISC_SEC_LIM   = 32'h00010000,
	parameter [31:0] DISC_SEG_LIM   = 32'h00000001,
	parameter [31:0] DISC_ALIGN     = 32'h00000008,
	parameter [31:0] ZF_SEC_LIM     = 32'h00010000,
	parameter [31:0] ZF_SEG_LIM     = 32'h00000001,
	parameter [7:0]  ZF_DEALLOC     = 8'h01,
	parameter        READ_ONLY      = 0,
	parameter        CACHE_RST_WB   = 1
) (
	// Clock and reset
	input  wire        I_CLK,
	input  wire        I_NRST,
	// APB slave
	input  wire        I_PSEL,
	input  wire        I_PENABLE,
	input  wire        I_PWRITE,
	input  wire [11:0] I_PADDR,
	input  wire [31:0] I_PWDATA,
	output reg         O_PREADY,
	output reg  [31:0] O_PRDATA,
	output reg         O_PSLVERR,
	// Request header or segment in
	input  wire        I_REQ_VALID,
	input  wire        I_REQ_IS_SEG,
	input  wire [31:0] I_REQ_TYPE,
	input  wire [63:0] I_REQ_SECTOR,
	input  wire [31:0] I_REQ_COUNT,
	input  wire [31:0] I_REQ_FLAGS,
	input  wire [31:0] I_REQ_SEG_TOTAL,
	// Completion and mode out
	output reg         O_DONE,
	output reg  [7:0]  O_STATUS,
	output reg         O_DATA_GO,
	output reg         O_DEALLOC,
	output reg  [63:0] O_BYTE_OFFSET,
	output reg         O_CACHE_WB,
	output reg         O_LEGACY
);
	// ****************************************************************
	// Local state
	// ****************************************************************
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_DONE = 2'b01;

	reg  [31:0] drv_feat_q;
	reg  [7:0]  dev_status_q;
	reg  [7:0]  cache_q;
	reg         cfg_legacy_q;
	reg  [1:0]  state_q;
	reg  [31:0] req_count_q;
	reg  [7:0]  last_status_q;
	wire [31:0] dev_feat;
	wire [31:0] neg_feat;
	wire [7:0]  dec_status;
	wire        dec_moves;
	wire        dec_dealloc;
	wire        apb_wr;
	wire        apb_rd;
	wire        st_wr;
	wire [31:0] new_status;

	// Offered features: flush always, cache switch only with it
	assign dev_feat = (32'h00000001 << `VBR_F_SIZE_LIMIT)
		| (32'h00000001 << `VBR_F_SEG_LIMIT)
		| (32'h00000001 << `VBR_F_GEOMETRY)
		| ((READ_ONLY ? 32'h00000001 : 32'h00000000) << `VBR_F_READ_ONLY)
		| (32'h00000001 << `VBR_F_BLK_SIZE)
		| (32'h00000001 << `VBR_F_FLUSH)
		| (32'h00000001 << `VBR_F_TOPOLOGY)
		| (32'h00000001 << `VBR_F_CACHE_MODE)
		| (32'h00000001 << `VBR_F_MULTI_QUEUE)
		| (32'h00000001 << `VBR_F_DISCARD)
		| (32'h00000001 << `VBR_F_ZERO_FILL);

	// Read-only is honoured as offered, other features as negotiated
	assign neg_feat = (dev_feat & drv_feat_q)
		| (dev_feat & (32'h00000001 << `VBR_F_READ_ONLY));

	assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE && !O_PREADY;
	assign apb_rd = I_PSEL && I_PENABLE && !I_PWRITE && !O_PREADY;
	assign st_wr  = apb_wr && (I_PADDR == `VBR_A_DEV_STATUS);
	assign new_status = I_PWDATA;

	// ****************************************************************
	// Byte-order helper
	// ****************************************************************
	// Modern access is little-endian words; legacy native order is
	// modelled as a byte swap of each word
	function [31:0] vbr_order;
		input [31:0] w;
		input        legacy;
		begin
			vbr_order = legacy ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
		end
	endfunction

	// ****************************************************************
	// Request decoder
	// ****************************************************************
	vbr_req_decode u_decode (
		.i_type         (I_REQ_TYPE),
		.i_flags        (I_REQ_FLAGS),
		.i_seg_count    (I_REQ_SEG_TOTAL),
		.i_is_segment   (I_REQ_IS_SEG),
		.i_features     (neg_feat),
		.i_disc_seg_lim (DISC_SEG_LIM),
		.i_zf_seg_lim   (ZF_SEG_LIM),
		.o_status       (dec_status),
		.o_moves_data   (dec_moves),
		.o_dealloc      (dec_dealloc)
	);

	// ****************************************************************
	// Register reads
	// ****************************************************************
	function [31:0] vbr_read;
		input [11:0] a;
		reg   [31:0] v;
		begin
			v = 32'h00000000;
			case (a)
				`VBR_A_CAP_LO:      v = CAPACITY[31:0];
				`VBR_A_CAP_HI:      v = CAPACITY[63:32];
				`VBR_A_SIZE_LIM:    v = SIZE_LIMIT;
				`VBR_A_SEG_LIM:     v = SEG_LIMIT;
				`VBR_A_GEOMETRY:    v = GEOMETRY;
				`VBR_A_BLK_SIZE:    v = BLK_BYTES;
				`VBR_A_TOPO0:       v = TOPO0;
				`VBR_A_OPT_IO:      v = OPT_IO;
				// Cache mode byte, zero pad byte, queue count
				`VBR_A_CACHE_Q:     v = {QUEUES, 8'h00, cache_q};
				`VBR_A_DISC_SEC:    v = DISC_SEC_LIM;
				`VBR_A_DISC_SEG:    v = DISC_SEG_LIM;
				`VBR_A_DISC_ALN:    v = DISC_ALIGN;
				`VBR_A_ZF_SEC:      v = ZF_SEC_LIM;
				`VBR_A_ZF_SEG:      v = ZF_SEG_LIM;
				`VBR_A_ZF_TAIL:     v = {24'h000000, ZF_DEALLOC};
				`VBR_A_DEV_FEAT:    v = dev_feat;
				`VBR_A_DRV_FEAT:    v = drv_feat_q;
				`VBR_A_DEV_STATUS:  v = {cfg_legacy_q, 23'h000000, dev_status_q};
				`VBR_A_QUEUES_USED: v = neg_feat[`VBR_F_MULTI_QUEUE] ?
					{16'h0000, QUEUES} : 32'h00000001;
				`VBR_A_REQ_STAT:    v = {req_count_q[23:0], last_status_q};
				default:            v = 32'h00000000;
			endcase
			// Control words stay in bus order; config fields follow mode
			if (a < `VBR_A_DEV_FEAT)
				vbr_read = vbr_order(v, cfg_legacy_q);
			else
				vbr_read = v;
		end
	endfunction

	function vbr_mapped;
		input [11:0] a;
		begin
			vbr_mapped = (a[1:0] == 2'b00) && (a <= `VBR_A_REQ_STAT) &&
				(a != 12'h03C);
		end
	endfunction

	// ****************************************************************
	// APB slave: one wait state, answer in the second access cycle
	// ****************************************************************
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= 32'h00000000;
			O_PSLVERR <= 1'b0;
		end else if (I_PSEL && I_PENABLE && !O_PREADY) begin
			O_PREADY  <= 1'b1;
			O_PSLVERR <= !vbr_mapped(I_PADDR);
			O_PRDATA  <= apb_rd ? vbr_read(I_PADDR) : 32'h00000000;
		end else begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
		end
	end

	// ****************************************************************
	// Negotiation and status registers
	// ****************************************************************
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			drv_feat_q   <= 32'h00000000;
			dev_status_q <= 8'h00;
			cfg_legacy_q <= 1'b0;
		end else if (apb_wr) begin
			if (I_PADDR == `VBR_A_DRV_FEAT)
				drv_feat_q <= I_PWDATA & dev_feat;
			if (st_wr) begin
				dev_status_q <= new_status[7:0];
				cfg_legacy_q <= new_status[`VBR_CFG_LEGACY_BIT];
			end
		end
	end

	// ****************************************************************
	// Cache mode
	// ****************************************************************
	// Legacy: besides cache register writes, only ready-set without the cache feature may change it
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			cache_q <= CACHE_RST_WB ? 8'h01 : `VBR_CACHE_WT;
		end else if (apb_wr && I_PADDR == `VBR_A_CACHE_Q) begin
			if (cfg_legacy_q || neg_feat[`VBR_F_CACHE_MODE])
				cache_q <= {7'h00, vbr_order(I_PWDATA, cfg_legacy_q) != 32'h00000000};
		end else if (st_wr && !cfg_legacy_q && new_status[`VBR_ST_FEAT_OK] &&
				!dev_status_q[`VBR_ST_FEAT_OK] && drv_feat_q[`VBR_F_CACHE_MODE] &&
				!drv_feat_q[`VBR_F_FLUSH]) begin
			cache_q <= `VBR_CACHE_WT;
		end else if (st_wr && cfg_legacy_q && new_status[`VBR_ST_DRV_OK] &&
				!dev_status_q[`VBR_ST_DRV_OK] && !drv_feat_q[`VBR_F_CACHE_MODE]) begin
			// Driver cannot switch: fall back to the flush-implied mode
			cache_q <= {7'h00, drv_feat_q[`VBR_F_FLUSH]};
		end
	end

	// ****************************************************************
	// Request completion
	// ****************************************************************
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			state_q       <= ST_IDLE;
			O_DONE        <= 1'b0;
			O_STATUS      <= `VBR_S_OK;
			O_DATA_GO     <= 1'b0;
			O_DEALLOC     <= 1'b0;
			O_BYTE_OFFSET <= 64'h0000000000000000;
			req_count_q   <= 32'h00000000;
			last_status_q <= `VBR_S_OK;
		end else begin
			case (state_q)
				ST_IDLE: begin
					O_DONE    <= 1'b0;
					O_DATA_GO <= 1'b0;
					O_DEALLOC <= 1'b0;
					if (I_REQ_VALID) begin
						state_q       <= ST_DONE;
						O_DONE        <= 1'b1;
						O_STATUS      <= dec_status;
						O_DATA_GO     <= dec_moves;
						O_DEALLOC     <= dec_dealloc;
						// Byte offset of read or of write not failed as read-only; zero otherwise
						O_BYTE_OFFSET <= dec_moves ? {I_REQ_SECTOR[54:0], 9'h000} :
							64'h0000000000000000;
						req_count_q   <= req_count_q + 32'h00000001;
						last_status_q <= dec_status;
					end
				end
				ST_DONE: begin
					state_q   <= ST_IDLE;
					O_DONE    <= 1'b0;
					O_DATA_GO <= 1'b0;
					O_DEALLOC <= 1'b0;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Mode outputs
	// ****************************************************************
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_CACHE_WB <= 1'b0;
			O_LEGACY   <= 1'b0;
		end else begin
			O_CACHE_WB <= cache_q[0];
			O_LEGACY   <= cfg_legacy_q;
		end
	end
endmodule // vbr_engine

//--- vbr_defs.vh
`ifndef VBR_DEFS_VH
`define VBR_DEFS_VH

// ****************************************************************
// Feature bit positions
// ****************************************************************
`define VBR_F_SIZE_LIMIT   1
`define VBR_F_SEG_LIMIT    2
`define VBR_F_GEOMETRY     4
`define VBR_F_READ_ONLY    5
`define VBR_F_BLK_SIZE     6
`define VBR_F_FLUSH        9
`define VBR_F_TOPOLOGY     10
`define VBR_F_CACHE_MODE   11
`define VBR_F_MULTI_QUEUE  12
`define VBR_F_DISCARD      13
`define VBR_F_ZERO_FILL    14

// ****************************************************************
// Request type codes and status values
// ****************************************************************
`define VBR_T_READ         32'h00000000
`define VBR_T_WRITE        32'h00000001
`define VBR_T_FLUSH        32'h00000004
`define VBR_T_DISCARD      32'h0000000B
`define VBR_T_ZERO_FILL    32'h0000000D
`define VBR_S_OK           8'h00
`define VBR_S_IO_ERROR     8'h01
`define VBR_S_UNSUPPORTED  8'h02
`define VBR_SEG_UNMAP_BIT  0

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VBR_A_CAP_LO       12'h000
`define VBR_A_CAP_HI       12'h004
`define VBR_A_SIZE_LIM     12'h008
`define VBR_A_SEG_LIM      12'h00C
`define VBR_A_GEOMETRY     12'h010
`define VBR_A_BLK_SIZE     12'h014
`define VBR_A_TOPO0        12'h018
`define VBR_A_OPT_IO       12'h01C
`define VBR_A_CACHE_Q      12'h020
`define VBR_A_DISC_SEC     12'h024
`define VBR_A_DISC_SEG     12'h028
`define VBR_A_DISC_ALN     12'h02C
`define VBR_A_ZF_SEC       12'h030
`define VBR_A_ZF_SEG       12'h034
`define VBR_A_ZF_TAIL      12'h038
`define VBR_A_DEV_FEAT     12'h040
`define VBR_A_DRV_FEAT     12'h044
`define VBR_A_DEV_STATUS   12'h048
`define VBR_A_QUEUES_USED  12'h04C
`define VBR_A_REQ_STAT     12'h050
`define VBR_CFG_LEGACY_BIT 31
`define VBR_ST_FEAT_OK     3
`define VBR_ST_DRV_OK      2
`define VBR_CACHE_WT       8'h00

`endif

//--- vbr_req_decode.v
`timescale 1ns/1ns
`include "vbr_defs.vh"

// Decodes one request header or segment into a completion status
module vbr_req_decode (
	// Request fields
	input  wire [31:0] i_type,
	input  wire [31:0] i_flags,
	input  wire [31:0] i_seg_count,
	input  wire        i_is_segment,
	// Device state
	input  wire [31:0] i_features,
	input  wire [31:0] i_disc_seg_lim,
	input  wire [31:0] i_zf_seg_lim,
	// Result
	output reg  [7:0]  o_status,
	output reg         o_moves_data,
	output reg         o_dealloc
);
	// ****************************************************************
	// Status decision
	// ****************************************************************
	always @* begin
		o_status     = `VBR_S_OK;
		o_moves_data = 1'b0;
		o_dealloc    = 1'b0;
		case (i_type)
			`VBR_T_READ: begin
				o_moves_data = 1'b1;
			end
			`VBR_T_WRITE: begin
				if (i_features[`VBR_F_READ_ONLY])
					o_status = `VBR_S_IO_ERROR;
				else
					o_moves_data = 1'b1;
			end
			`VBR_T_FLUSH: begin
				if (!i_features[`VBR_F_FLUSH])
					o_status = `VBR_S_UNSUPPORTED;
			end
			`VBR_T_DISCARD: begin
				// Unmap is not honoured on discard; reserved flags refuse
				if (!i_features[`VBR_F_DISCARD] || i_flags != 32'h00000000)
					o_status = `VBR_S_UNSUPPORTED;
				else if (i_is_segment && (i_seg_count == 32'h00000000 ||
						i_seg_count > i_disc_seg_lim))
					o_status = `VBR_S_IO_ERROR;
			end
			`VBR_T_ZERO_FILL: begin
				if (!i_features[`VBR_F_ZERO_FILL] || i_flags[31:1] != 31'h00000000)
					o_status = `VBR_S_UNSUPPORTED;
				else if (i_is_segment && (i_seg_count == 32'h00000000 ||
						i_seg_count > i_zf_seg_lim))
					o_status = `VBR_S_IO_ERROR;
				else
					o_dealloc = i_flags[`VBR_SEG_UNMAP_BIT];
			end
			default: begin
				o_status = `VBR_S_UNSUPPORTED;
			end
		endcase
	end
endmodule // vbr_req_decode

//--- vbr_checker.sv
`timescale 1ns/1ns
// ****
// Request and APB timing checks
// ****
module vbr_checker (
	// Clock and reset
	input wire        I_CLK,
	input wire        I_NRST,
	// APB handshake
	input wire        I_PSEL,
	input wire        I_PENABLE,
	input wire        O_PREADY,
	// Requests and completions
	input wire        I_REQ_VALID,
	input wire        I_REQ_IS_SEG,
	input wire [31:0] I_REQ_TYPE,
	input wire [63:0] I_REQ_SECTOR,
	input wire [31:0] I_REQ_FLAGS,
	input wire        O_DONE,
	input wire [7:0]  O_STATUS,
	input wire        O_DATA_GO,
	input wire        O_DEALLOC,
	input wire [63:0] O_BYTE_OFFSET
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);
	// Request taken while the engine is idle
	sequence s_take;
		I_REQ_VALID && !O_DONE;
	endsequence
	sequence s_hdr_rw;
		s_take ##0 (!I_REQ_IS_SEG && I_REQ_TYPE <= 32'h00000001);
	endsequence
	sequence s_hdr_other;
		s_take ##0 (!I_REQ_IS_SEG && I_REQ_TYPE > 32'h00000001);
	endsequence
	sequence s_unknown;
		s_take ##0 (!I_REQ_IS_SEG && !(I_REQ_TYPE inside {32'h0, 32'h1, 32'h4, 32'hB, 32'hD}));
	endsequence
	sequence s_zf_unmap;
		s_take ##0 (I_REQ_IS_SEG && I_REQ_TYPE == 32'h0000000D && I_REQ_FLAGS[0]);
	endsequence
	// APB answer timing
	a_ready_after_access: assert property ((I_PSEL && I_PENABLE && !O_PREADY) |=> O_PREADY)
		else $error("ready missing after access");
	a_ready_one_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	// Completion timing and fields
	a_done_one_cycle: assert property (s_take |=> O_DONE ##1 !O_DONE)
		else $error("completion pulse wrong");
	a_offset_rw: assert property (s_hdr_rw |=> O_BYTE_OFFSET == ($past(I_REQ_SECTOR) << 9))
		else $error("byte offset wrong");
	a_offset_other: assert property (s_hdr_other |=> O_BYTE_OFFSET == 64'h0000000000000000)
		else $error("byte offset not zero");
	a_status_codes: assert property (O_DONE |-> O_STATUS <= 8'h02)
		else $error("status code out of range");
	a_status_held: assert property (!O_DONE |-> $stable(O_STATUS))
		else $error("status changed without completion");
	a_unknown_unsup: assert property (s_unknown |=> O_STATUS == 8'h02 && !O_DATA_GO)
		else $error("unknown type not unsupported");
	a_discard_unmap: assert property (
		s_take ##0 (I_REQ_IS_SEG && I_REQ_TYPE == 32'h0000000B && I_REQ_FLAGS[0])
		|=> O_STATUS == 8'h02)
		else $error("discard with unmap accepted");
	a_dealloc_cause: assert property (O_DEALLOC |-> $past(I_REQ_FLAGS[0]) && O_DONE)
		else $error("dealloc without unmap");
	a_zf_dealloc_seen: cover property (s_zf_unmap);
endmodule // vbr_checker

//--- vbr_guest_model.sv
`timescale 1ns/1ns
// ****
// Guest side: presents request headers and segments
// ****
module vbr_guest_model (
	// Clock
	input  wire         i_clk,
	// Completion from the engine
	input  wire         i_done,
	input  wire  [7:0]  i_status,
	input  wire         i_go,
	input  wire         i_dealloc,
	input  wire  [63:0] i_offset,
	// Request to the engine
	output logic        o_valid,
	output logic        o_is_seg,
	output logic [31:0] o_type,
	output logic [63:0] o_sector,
	output logic [31:0] o_count,
	output logic [31:0] o_flags,
	output logic [31:0] o_total
);
	logic        r_done;
	logic        r_go;
	logic        r_dl;
	logic [7:0]  r_st;
	logic [63:0] r_off;
	// Idle lines at time zero
	initial begin
		{o_valid, o_is_seg, o_type, o_sector, o_count, o_flags, o_total} = '0;
	end
	// One request; completion is sampled one cycle after the take
	task automatic send(input logic [31:0] t, input logic s, input logic [63:0] sec,
		input logic [31:0] f, input logic [31:0] n);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_is_seg <= s;
		o_type <= t;
		o_sector <= (s || t <= 32'h1) ? sec : 64'h0;
		o_count <= 32'h00000001;
		o_flags <= f;
		o_total <= n;
		@(posedge i_clk);
		o_valid <= 1'b0;
		// Released type, sector, flags and total lines carry junk, not the last value
		{o_type, o_sector, o_flags, o_total} <= ~{o_type, o_sector, o_flags, o_total};
		@(posedge i_clk);
		r_done = i_done;
		r_st = i_status;
		r_go = i_go;
		r_dl = i_dealloc;
		r_off = i_offset;
	endtask
endmodule // vbr_guest_model

//--- vbr_engine_tb.sv
`timescale 1ns/1ns
`include "vbr_defs.vh"
module vbr_engine_tb;
	localparam [63:0] CAP = 64'h0000000100002000;
	localparam [15:0] QN = 16'h0003;
	localparam [31:0] DSEC = 32'h00000400;
	typedef struct {
		logic [31:0] t; logic s; logic [63:0] sec; logic [31:0] f; logic [31:0] n;
		logic [7:0] st; logic go; logic dl;
	} vbr_row_t;
	logic        I_CLK, I_NRST, I_PSEL, I_PENABLE, I_PWRITE;
	logic [11:0] I_PADDR;
	logic [31:0] I_PWDATA, rd, feat;
	logic        err;
	wire         O_PREADY, O_PSLVERR, O_DONE, O_DATA_GO, O_DEALLOC, O_CACHE_WB, O_LEGACY;
	wire  [31:0] O_PRDATA, r_type, r_count, r_flags, r_total;
	wire  [7:0]  O_STATUS;
	wire  [63:0] O_BYTE_OFFSET, r_sector;
	wire         r_valid, r_seg;
	int          miscompares, n_checks;
	vbr_row_t    rows [11] = '{
		'{`VBR_T_READ, 0, 64'h3, 0, 0, `VBR_S_OK, 1, 0},
		'{`VBR_T_WRITE, 0, 64'h5, 0, 0, `VBR_S_OK, 1, 0},
		'{`VBR_T_FLUSH, 0, 64'h0, 0, 0, `VBR_S_OK, 1'bx, 0},
		'{32'h7, 0, 64'h0, 0, 0, `VBR_S_UNSUPPORTED, 0, 0},
		'{`VBR_T_DISCARD, 1, 64'h10, 0, 1, `VBR_S_OK, 1'bx, 0},
		'{`VBR_T_DISCARD, 1, 64'h10, 1, 1, `VBR_S_UNSUPPORTED, 1'bx, 0},
		'{`VBR_T_ZERO_FILL, 1, 64'h20, 1, 1, `VBR_S_OK, 1'bx, 1},
		'{`VBR_T_ZERO_FILL, 1, 64'h20, 0, 1, `VBR_S_OK, 1'bx, 0},
		'{`VBR_T_ZERO_FILL, 1, 64'h20, 0, 2, `VBR_S_IO_ERROR, 1'bx, 0},
		'{`VBR_T_DISCARD, 1, 64'h10, 0, 0, `VBR_S_IO_ERROR, 1'bx, 0},
		'{`VBR_T_READ, 0, 64'h7FFFFF, 0, 0, `VBR_S_OK, 1, 0}};
	// Engine and guest model
	vbr_engine #(.CAPACITY(CAP), .QUEUES(QN), .DISC_SEC_LIM(DSEC)) u_vbr_engine (
		.I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
		.I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
		.O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .I_REQ_VALID(r_valid),
		.I_REQ_IS_SEG(r_seg), .I_REQ_TYPE(r_type), .I_REQ_SECTOR(r_sector),
		.I_REQ_COUNT(r_count), .I_REQ_FLAGS(r_flags), .I_REQ_SEG_TOTAL(r_total),
		.O_DONE(O_DONE), .O_STATUS(O_STATUS), .O_DATA_GO(O_DATA_GO), .O_DEALLOC(O_DEALLOC),
		.O_BYTE_OFFSET(O_BYTE_OFFSET), .O_CACHE_WB(O_CACHE_WB), .O_LEGACY(O_LEGACY));
	vbr_guest_model u_guest (.i_clk(I_CLK), .i_done(O_DONE), .i_status(O_STATUS),
		.i_go(O_DATA_GO), .i_dealloc(O_DEALLOC), .i_offset(O_BYTE_OFFSET), .o_valid(r_valid),
		.o_is_seg(r_seg), .o_type(r_type), .o_sector(r_sector), .o_count(r_count),
		.o_flags(r_flags), .o_total(r_total));
	// Clock
	initial begin
		I_CLK = 1'b0;
		forever #10 I_CLK = ~I_CLK;
	end
	task summarize;
		if (miscompares == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer, held until ready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge I_CLK);
		{I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {2'b10, w, a, d};
		@(posedge I_CLK);
		I_PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge I_CLK);
			k++;
		end while (O_PREADY !== 1'b1 && k < 16);
		rd = O_PRDATA;
		err = O_PSLVERR;
		{I_PSEL, I_PENABLE} <= 2'b00;
		if (k >= 16) begin
			miscompares++;
			summarize();
		end
	endtask
	// Main sequence
	initial begin
		{I_NRST, I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} = '0;
		{miscompares, n_checks} = '0;
		repeat (2) @(posedge I_CLK);
		I_NRST <= 1'b1;
		apb(0, `VBR_A_QUEUES_USED, 0); check("queues_used", rd, 1);
		apb(0, `VBR_A_CAP_LO, 0); check("cap_lo", rd, CAP[31:0]);
		apb(0, `VBR_A_CAP_HI, 0); check("cap_hi", rd, CAP[63:32]);
		apb(0, `VBR_A_DEV_FEAT, 0);
		feat = rd;
		check("flush_offer", {feat[11] & ~feat[9], feat[9]}, 1);
		check("ro_offer", feat[5], 0);
		apb(0, `VBR_A_ZF_TAIL, 0); check("tail_pad", rd, 32'h00000001);
		apb(0, `VBR_A_DISC_SEC, 0); check("disc_sec", rd, DSEC);
		apb(0, 12'h03C, 0); check("hole_err", {err, rd}, 33'h100000000);
		apb(1, 12'h054, 0); check("far_err", err, 1);
		apb(1, `VBR_A_DRV_FEAT, 32'h00001800);
		apb(1, `VBR_A_DEV_STATUS, 32'h00000008);
		apb(0, `VBR_A_CACHE_Q, 0); check("cache_wt", rd, {QN, 16'h0000});
		check("cache_pin", O_CACHE_WB, 0);
		apb(0, `VBR_A_QUEUES_USED, 0); check("queues_mq", rd, QN);
		u_guest.send(`VBR_T_FLUSH, 0, 0, 0, 0); check("no_flush", u_guest.r_st, 2);
		apb(1, `VBR_A_CACHE_Q, 32'h00000001);
		apb(0, `VBR_A_CACHE_Q, 0); check("cache_wb", {O_CACHE_WB, rd[7:0]}, 9'h101);
		apb(1, `VBR_A_DRV_FEAT, feat);
		foreach (rows[i]) begin
			u_guest.send(rows[i].t, rows[i].s, rows[i].sec, rows[i].f, rows[i].n);
			check("done", u_guest.r_done, 1);
			check("status", u_guest.r_st, rows[i].st);
			if (rows[i].go !== 1'bx) check("go", u_guest.r_go, rows[i].go);
			check("dealloc", u_guest.r_dl, rows[i].dl);
			if (!rows[i].s) check("offset", u_guest.r_off, rows[i].t <= 1 ? rows[i].sec << 9 : 0);
		end
		// Legacy: native order, cache mode kept across status and feature writes
		apb(1, `VBR_A_DEV_STATUS, 32'h80000000);
		apb(0, `VBR_A_CAP_LO, 0); check("cap_legacy", rd, 32'h00200000);
		check("legacy_pin", O_LEGACY, 1);
		apb(1, `VBR_A_DRV_FEAT, 32'h00000800); check("wb_feat", O_CACHE_WB, 1);
		apb(1, `VBR_A_DEV_STATUS, 32'h80000004); check("wb_ready", O_CACHE_WB, 1);
		// Legacy ready without the cache feature and no flush: writethrough
		apb(1, `VBR_A_DRV_FEAT, 32'h00000000);
		apb(1, `VBR_A_DEV_STATUS, 32'h80000000);
		apb(1, `VBR_A_DEV_STATUS, 32'h80000004);
		apb(0, `VBR_A_CACHE_Q, 0); check("wt_ready", rd, 32'h00000300);
		check("wt_ready_pin", O_CACHE_WB, 0);
		// Mid-run reset: mode back to writeback, legacy and status cleared
		@(posedge I_CLK);
		I_NRST <= 1'b0;
		repeat (2) @(posedge I_CLK);
		I_NRST <= 1'b1;
		apb(0, `VBR_A_DEV_STATUS, 0); check("status_rst", rd, 0);
		check("legacy_rst", O_LEGACY, 0);
		check("wb_rst", O_CACHE_WB, 1);
		summarize();
	end
endmodule // vbr_engine_tb
bind vbr_engine vbr_checker u_vbr_checker (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .O_PREADY(O_PREADY), .I_REQ_VALID(I_REQ_VALID),
	.I_REQ_IS_SEG(I_REQ_IS_SEG), .I_REQ_TYPE(I_REQ_TYPE), .I_REQ_SECTOR(I_REQ_SECTOR),
	.I_REQ_FLAGS(I_REQ_FLAGS), .O_DONE(O_DONE), .O_STATUS(O_STATUS), .O_DATA_GO(O_DATA_GO),
	.O_DEALLOC(O_DEALLOC), .O_BYTE_OFFSET(O_BYTE_OFFSET));
